/* File: hw/cbsps_pkg.sv */
// cbsps_pkg: offsets and bit positions of the socket present state block
// assumes a 32-bit register port with one-cycle read latency
package cbsps_pkg;
  localparam int          REG_AW              = 8;
  localparam logic [7:0]  OFF_PRESENT_STATE   = 8'h08;
  localparam logic [7:0]  OFF_FORCE_EVENT     = 8'h0C;
  localparam logic [7:0]  OFF_SOCKET_EVENT    = 8'h00;
  localparam logic [7:0]  OFF_INTERROG_CTRL   = 8'h20;
  localparam logic [7:0]  OFF_DEVICE_CTRL     = 8'h24;
  // present state bit positions
  localparam int B_CAP_VY   = 31;
  localparam int B_CAP_VX   = 30;
  localparam int B_CAP_3V3  = 29;
  localparam int B_CAP_5V0  = 28;
  localparam int B_CARD_VY  = 13;
  localparam int B_CARD_VX  = 12;
  localparam int B_CARD_3V3 = 11;
  localparam int B_CARD_5V0 = 10;
  localparam int B_BADV     = 9;
  localparam int B_DLOST    = 8;
  localparam int B_NOTCARD  = 7;
  localparam int B_IRQ      = 6;
  localparam int B_CARDBUS_TYPE_DETECTED   = 5;
  localparam int B_L16CARD  = 4;
  localparam int B_PWR      = 3;
  localparam int B_DET_B    = 2;
  localparam int B_DET_A    = 1;
  localparam int B_STS      = 0;
  // device control bit that withdraws 5 V socket capability
  localparam int B_DEVCTL_NO5V = 6;
  // forced no-3.3 V socket capability override (bit of our own interrogation control reg)
  localparam int B_FORCE_NO3V  = 15;
  // socket event bits
  localparam int E_PWR   = 3;
  localparam int E_DET_B = 2;
  localparam int E_DET_A = 1;
  localparam int E_STS   = 0;
  localparam int B_INT_BUSY = 0;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

/* File: hw/cbsps_sync.sv */
// cbsps_sync: two-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
module cbsps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: hw/cbsps_present_state.sv */
// cbsps_present_state: socket present state register, socket event flags,
// force-event writes and card interrogation latches for one socket
// assumes a plain register port; card pins are asynchronous to clk
`timescale 1ns/1ns
module cbsps_present_state
  import cbsps_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic [cbsps_pkg::REG_AW-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata,
  input  wire logic                    card_detect_a_pin,
  input  wire logic                    card_detect_b_pin,
  input  wire logic                    card_status_change_pin,
  input  wire logic                    card_ready_irq_pin,
  input  wire logic                    interrog_done,
  input  wire logic [3:0]              interrog_vcc,
  input  wire logic                    interrog_cardbus,
  input  wire logic                    interrog_legacy16,
  input  wire logic                    interrog_invalid,
  input  wire logic                    socket_powered,
  input  wire logic                    invalid_supply_request,
  input  wire logic                    removal_data_loss,
  output logic                         identifying
);
  import cbsps_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic [3:0]  card_v;     // vy, vx, 3v3, 5v0
    logic        badv;
    logic        dlost;
    logic        notcard;
    logic        cardbus_type_detected;
    logic        l16card;
    logic        det_a;
    logic        det_b;
    logic        pwr;
    logic        sts;
    logic [3:0]  event_flags;
    logic        busy;
    logic        devctl_no5v;
    logic        force_no3v;
  } cbsps_state_t;

  cbsps_state_t st;
  cbsps_state_t next_st;
  logic         rst_n;
  logic [1:0]   rst_sync;
  logic [3:0]   pins_s;

  // kept outside the state struct: the only flop pair on the raw reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  cbsps_sync #(.W(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({card_ready_irq_pin, card_status_change_pin, ~card_detect_b_pin,
             ~card_detect_a_pin}),
    .q     (pins_s)
  );

  logic irq_s;
  logic sts_s;
  logic det_b_s;
  logic det_a_s;
  logic det_b_n;
  logic det_a_n;
  // detect pins idle high; synced inverted so the cleared flops read
  // as no card and no false detect event follows reset
  assign {irq_s, sts_s, det_b_n, det_a_n} = pins_s;
  assign det_b_s = !det_b_n;
  assign det_a_s = !det_a_n;

  function automatic logic [31:0] present_word(input cbsps_state_t s, input logic irq);
    logic [31:0] w;
    w = ZERO32;
    w[B_CAP_VY]  = 1'b0;
    w[B_CAP_VX]  = 1'b0;
    w[B_CAP_3V3] = !s.force_no3v;
    w[B_CAP_5V0] = !s.devctl_no5v;
    w[B_CARD_VY]  = s.card_v[3];
    w[B_CARD_VX]  = s.card_v[2];
    w[B_CARD_3V3] = s.card_v[1];
    w[B_CARD_5V0] = s.card_v[0];
    w[B_BADV]    = s.badv;
    w[B_DLOST]   = s.dlost;
    w[B_NOTCARD] = s.notcard;
    w[B_IRQ]     = irq;
    w[B_CARDBUS_TYPE_DETECTED]  = s.cardbus_type_detected;
    w[B_L16CARD] = s.l16card;
    w[B_PWR]     = s.pwr;
    w[B_DET_B]   = s.det_b;
    w[B_DET_A]   = s.det_a;
    w[B_STS]     = s.sts;
    return w;
  endfunction

  logic wr_force;
  logic wr_event;
  logic wr_ictl;
  logic wr_devctl;
  assign wr_force  = wr && (addr == OFF_FORCE_EVENT);
  assign wr_event  = wr && (addr == OFF_SOCKET_EVENT);
  assign wr_ictl   = wr && (addr == OFF_INTERROG_CTRL);
  assign wr_devctl = wr && (addr == OFF_DEVICE_CTRL);
  assign identifying = st.busy;

  always_comb begin
    logic [3:0] ev;
    ev = 4'h0;
    next_st = st;
    // interrogation window opens only by a software write of the interrogation control busy bit
    if (wr_ictl) begin
      next_st.busy       = wdata[B_INT_BUSY];
      next_st.force_no3v = wdata[B_FORCE_NO3V];
    end
    if (wr_devctl) begin
      next_st.devctl_no5v = wdata[B_DEVCTL_NO5V];
    end
    if (interrog_done) begin
      next_st.busy    = 1'b0;
      next_st.card_v  = interrog_vcc;
      next_st.cardbus_type_detected  = interrog_cardbus;
      next_st.l16card = interrog_legacy16;
      next_st.notcard = interrog_invalid;
    end
    next_st.badv  = invalid_supply_request;
    next_st.dlost = removal_data_loss;
    if (!st.busy) begin
      next_st.det_a = det_a_s;
      next_st.det_b = det_b_s;
    end
    next_st.pwr = socket_powered;
    next_st.sts = sts_s;
    if (st.pwr != next_st.pwr) ev[E_PWR] = 1'b1;
    if (st.det_a != next_st.det_a) ev[E_DET_A] = 1'b1;
    if (st.det_b != next_st.det_b) ev[E_DET_B] = 1'b1;
    if (st.sts != next_st.sts) begin
      ev[E_STS] = st.cardbus_type_detected ? next_st.sts : 1'b1;
    end
    if (wr_force) begin
      next_st.card_v[3] = wdata[B_CARD_VY];
      next_st.card_v[2] = wdata[B_CARD_VX];
      next_st.card_v[1] = wdata[B_CARD_3V3];
      next_st.card_v[0] = wdata[B_CARD_5V0];
      if (wdata[B_BADV])    next_st.badv    = 1'b1;
      if (wdata[B_DLOST])   next_st.dlost   = 1'b1;
      if (wdata[B_NOTCARD]) next_st.notcard = 1'b1;
      if (wdata[B_CARDBUS_TYPE_DETECTED])  next_st.cardbus_type_detected  = 1'b1;
      if (wdata[B_L16CARD]) next_st.l16card = 1'b1;
      ev = ev | wdata[3:0];
    end
    // set wins over write-one-to-clear
    next_st.event_flags = st.event_flags & ~(wr_event ? wdata[3:0] : 4'h0);
    next_st.event_flags = next_st.event_flags | ev;
    // reads only sample; no state changes on read
    if (rd) begin
      if (addr == OFF_PRESENT_STATE) begin
        next_st.rdata = present_word(st, irq_s);
      end else if (addr == OFF_SOCKET_EVENT) begin
        next_st.rdata = {28'h0000000, st.event_flags};
      end else begin
        next_st.rdata = ZERO32;
      end
    end else begin
      next_st.rdata = ZERO32;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.rdata       <= 32'h0000_0000;
      st.card_v      <= 4'h0;
      st.badv        <= 1'b0;
      st.dlost       <= 1'b0;
      st.notcard     <= 1'b0;
      st.cardbus_type_detected      <= 1'b0;
      st.l16card     <= 1'b0;
      st.det_a       <= 1'b1;
      st.det_b       <= 1'b1;
      st.pwr         <= 1'b0;
      st.sts         <= 1'b0;
      st.event_flags <= 4'h0;
      st.busy        <= 1'b0;
      st.devctl_no5v <= 1'b0;
      st.force_no3v  <= 1'b0;
    end else begin
      st.rdata       <= next_st.rdata;
      st.card_v      <= next_st.card_v;
      st.badv        <= next_st.badv;
      st.dlost       <= next_st.dlost;
      st.notcard     <= next_st.notcard;
      st.cardbus_type_detected      <= next_st.cardbus_type_detected;
      st.l16card     <= next_st.l16card;
      st.det_a       <= next_st.det_a;
      st.det_b       <= next_st.det_b;
      st.pwr         <= next_st.pwr;
      st.sts         <= next_st.sts;
      st.event_flags <= next_st.event_flags;
      st.busy        <= next_st.busy;
      st.devctl_no5v <= next_st.devctl_no5v;
      st.force_no3v  <= next_st.force_no3v;
    end
  end
  assign rdata = st.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_change;
    st.busy && $changed(det_a_s);
  endsequence

  a_detect_frozen: assert property (s_busy_change |=> $stable(st.det_a))
    else $error("detect bit moved during identification");
  a_detect_follow: assert property (!st.busy ##1 !st.busy |-> st.det_a == $past(det_a_s))
    else $error("detect bit not following pin");
  sequence s_read_state;
    rd && addr == OFF_PRESENT_STATE;
  endsequence

  sequence s_read_event;
    rd && addr == OFF_SOCKET_EVENT;
  endsequence

  sequence s_no_update;
    !interrog_done && !wr_force;
  endsequence

  // falling status pin on a cardbus card with nothing else setting the flag
  sequence s_cb_fall;
    st.cardbus_type_detected && st.sts && !next_st.sts && !wr_force && !wr_event && !st.event_flags[E_STS];
  endsequence

  a_cap_fixed: assert property (s_read_state |=> rdata[31:30] == '0 && rdata[27:14] == '0)
    else $error("reserved or unsupported capability bits set");
  a_cap_5v0: assert property (s_read_state |=> rdata[B_CAP_5V0] == !$past(st.devctl_no5v))
    else $error("5 V capability wrong");
  a_cap_3v3: assert property (s_read_state |=> rdata[B_CAP_3V3] == !$past(st.force_no3v))
    else $error("3.3 V capability wrong");
  a_type_hold: assert property (s_no_update |=> $stable(st.cardbus_type_detected) && $stable(st.card_v))
    else $error("card type moved without interrogation");
  a_irq_level: assert property (s_read_state |=> rdata[B_IRQ] == $past(irq_s))
    else $error("ready irq bit wrong");
  a_pwr_event: assert property ($changed(st.pwr) |-> st.event_flags[E_PWR])
    else $error("power change left no event");
  a_sts_cb_edge: assert property (s_cb_fall |=> !st.event_flags[E_STS])
    else $error("cardbus falling edge set event");
  a_status_mirror: assert property (##1 st.sts == $past(sts_s))
    else $error("status bit not mirroring pin");
  a_force_card_v: assert property (wr_force |=>
    st.card_v == $past(wdata[B_CARD_VY:B_CARD_5V0]))
    else $error("forced card voltage bits not written");
  a_force_notcard: assert property (wr_force && wdata[B_NOTCARD] |=> st.notcard)
    else $error("forced unrecognized card not shown");
  a_badv_level: assert property (!wr_force |=> st.badv == $past(invalid_supply_request))
    else $error("invalid supply bit not following request");
  a_dlost_level: assert property (!wr_force |=> st.dlost == $past(removal_data_loss))
    else $error("data loss bit not following input");
  a_notcard_hold: assert property (s_no_update |=> $stable(st.notcard))
    else $error("unrecognized card bit moved");
  a_l16_hold: assert property (s_no_update |=> $stable(st.l16card))
    else $error("16-bit card bit moved");
  a_pwr_follow: assert property (##1 st.pwr == $past(socket_powered))
    else $error("power bit not following socket power");
  a_det_event: assert property ($changed(st.det_a) |-> st.event_flags[E_DET_A])
    else $error("detect change left no event");
  a_sts_16_edge: assert property (!st.cardbus_type_detected && st.sts != next_st.sts |=>
    st.event_flags[E_STS])
    else $error("16-bit status edge left no event");
  a_read_quiet: assert property (!rd |=> rdata == ZERO32)
    else $error("read data not zero outside a read");
  a_state_card_v: assert property (s_read_state |=>
    rdata[B_CARD_VY:B_CARD_5V0] == $past(st.card_v))
    else $error("card voltage bits read wrong");
  a_event_read: assert property (s_read_event |=>
    rdata[E_PWR:E_STS] == $past(st.event_flags) && rdata[31:E_PWR+1] == '0)
    else $error("event register read wrong");
  a_identify_flag: assert property (interrog_done |=> !identifying)
    else $error("identification window not closed");
endmodule

/* File: testbench/cbsps_card_model.sv */
// cbsps_card_model: removable card as seen at the socket pins
// assumes the bench changes its controls just after a rising edge
`timescale 1ns/1ns
module cbsps_card_model (
  input  wire logic clk,
  input  wire logic seat_a,
  input  wire logic seat_b,
  input  wire logic sts_level,
  input  wire logic irq_level,
  output logic      card_detect_a_pin = 1'b1,
  output logic      card_detect_b_pin = 1'b1,
  output logic      card_status_change_pin = 1'b0,
  output logic      card_ready_irq_pin = 1'b0
);
  logic seated;
  assign seated = seat_a | seat_b;
  // detect lines pulled up, grounded by the seated contact
  // status and ready lines pulled down, so an absent card reads low
  always @(posedge clk) begin
    card_detect_a_pin <= ~seat_a;
    card_detect_b_pin <= ~seat_b;
    card_status_change_pin <= seated & sts_level;
    card_ready_irq_pin <= seated & irq_level;
  end
endmodule

/* File: testbench/tb_cbsps_present_state.sv */
// tb_cbsps_present_state: self-checking bench for the socket present state block
// assumes cbsps_pkg, the design and the card model are compiled first
`timescale 1ns/1ns
module tb_cbsps_present_state;
  import cbsps_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, done = 1'b0;
  logic        ins_a = 1'b0, ins_b = 1'b0, sts = 1'b0, irq = 1'b0;
  logic        icb = 1'b0, il16 = 1'b0, iinv = 1'b0;
  logic        pwr = 1'b0, badv = 1'b0, dloss = 1'b0;
  logic [3:0]  ivcc = 4'h0;
  logic [31:0] rdata, r, seed = 32'hB53A181F;
  logic        det_a, det_b, sts_pin, irq_pin, identifying;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  int          m_cap3 = 1, m_cap5 = 1, m_card = 0, m_cb = 0, m_l16 = 0, m_notc = 0;
  int          m_ev = 0, m_da = 1, m_db = 1, m_sts = 0, m_irq = 0;

  always #5 clk = ~clk;

  cbsps_card_model u_cbsps_card_model (.clk(clk), .seat_a(ins_a), .seat_b(ins_b),
    .sts_level(sts), .irq_level(irq), .card_detect_a_pin(det_a),
    .card_detect_b_pin(det_b), .card_status_change_pin(sts_pin),
    .card_ready_irq_pin(irq_pin));

  cbsps_present_state u_cbsps_present_state (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .card_detect_a_pin(det_a),
    .card_detect_b_pin(det_b), .card_status_change_pin(sts_pin),
    .card_ready_irq_pin(irq_pin), .interrog_done(done), .interrog_vcc(ivcc),
    .interrog_cardbus(icb), .interrog_legacy16(il16), .interrog_invalid(iinv),
    .socket_powered(pwr), .invalid_supply_request(badv),
    .removal_data_loss(dloss), .identifying(identifying));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] exp_state();
    return {2'h0, m_cap3[0], m_cap5[0], 14'h0, m_card[3:0], badv, dloss, m_notc[0],
            m_irq[0], m_cb[0], m_l16[0], pwr, m_db[0], m_da[0], m_sts[0]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask

  // drives seat, status, ready, power and flag levels; model tracks events
  task automatic apply(input logic [6:0] v);
    int s;
    s = v[2] & (v[0] | v[1]);
    @(posedge clk);
    ins_a <= v[0];
    ins_b <= v[1];
    sts <= v[2];
    irq <= v[3];
    pwr <= v[4];
    badv <= v[5];
    dloss <= v[6];
    if (v[4] != pwr) m_ev |= 8;
    if (int'(!v[0]) != m_da) m_ev |= 2;
    if (int'(!v[1]) != m_db) m_ev |= 4;
    if (s != m_sts && (m_cb == 0 || s == 1)) m_ev |= 1;
    m_da = !v[0];
    m_db = !v[1];
    m_sts = s;
    m_irq = v[3] & (v[0] | v[1]);
    repeat (6) @(posedge clk);
  endtask

  task automatic run_random(input int n);
    for (int k = 0; k < n; k++) begin
      r = rnd();
      apply(r[6:0]);
      chk_reg("state", OFF_PRESENT_STATE, exp_state());
      chk_reg("events", OFF_SOCKET_EVENT, 32'(m_ev));
      wr_reg(OFF_SOCKET_EVENT, 32'hF);
      m_ev = 0;
    end
  endtask

  // detect toggles during identification must not show; latches only on done
  task automatic interrog(input int cb);
    logic [31:0] v;
    v = rnd();
    // card held on contact b so status and ready stay put while a toggles
    apply(7'h02);
    wr_reg(OFF_INTERROG_CTRL, 32'h1);
    @(posedge clk);
    ins_a <= !ins_a;
    repeat (6) @(posedge clk);
    check("identifying", 32'h1, {31'h0, identifying});
    chk_reg("frozen", OFF_PRESENT_STATE, exp_state());
    @(posedge clk);
    ins_a <= !ins_a;
    repeat (6) @(posedge clk);
    ivcc <= v[3:0];
    icb <= cb[0];
    il16 <= !cb[0];
    iinv <= !cb[0];
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    m_card = v[3:0];
    m_cb = cb;
    m_l16 = !cb;
    m_notc = !cb;
    repeat (6) @(posedge clk);
    check("idle", 32'h0, {31'h0, identifying});
    ivcc <= ~v[3:0];
    icb <= !cb[0];
    il16 <= cb[0];
    iinv <= cb[0];
    repeat (4) @(posedge clk);
    chk_reg("latched", OFF_PRESENT_STATE, exp_state());
    chk_reg("id ev", OFF_SOCKET_EVENT, 32'(m_ev));
  endtask

  // run should end near 550 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg("reset", OFF_PRESENT_STATE, exp_state());
    chk_reg("reset ev", OFF_SOCKET_EVENT, 32'h0);
    wr_reg(OFF_PRESENT_STATE, 32'hFFFFFFFF);
    chk_reg("ro", OFF_PRESENT_STATE, exp_state());
    chk_reg("unmapped", 8'h40, 32'h0);
    wr_reg(OFF_DEVICE_CTRL, 32'h40);
    wr_reg(OFF_INTERROG_CTRL, 32'h8000);
    m_cap3 = 0;
    m_cap5 = 0;
    chk_reg("caps off", OFF_PRESENT_STATE, exp_state());
    wr_reg(OFF_DEVICE_CTRL, 32'h0);
    wr_reg(OFF_INTERROG_CTRL, 32'h0);
    m_cap3 = 1;
    m_cap5 = 1;
    chk_reg("caps on", OFF_PRESENT_STATE, exp_state());
    run_random(16);
    interrog(0);
    interrog(1);
    run_random(16);
    r = rnd();
    wr_reg(OFF_FORCE_EVENT, {18'h0, r[3:0], 10'h08F});
    m_card = r[3:0];
    m_notc = 1;
    m_ev |= 15;
    chk_reg("forced", OFF_PRESENT_STATE, exp_state());
    chk_reg("forced ev", OFF_SOCKET_EVENT, 32'(m_ev));
    wr_reg(OFF_SOCKET_EVENT, 32'h5);
    m_ev &= 10;
    chk_reg("cleared ev", OFF_SOCKET_EVENT, 32'(m_ev));
    finish_test();
  end
endmodule
